/* core/ahs_ctrl.sv */
// alarm contact, humidity heater and optical self-test controller with axi4-lite registers
// Operation
// - contact pair held closed while idle, opened when the alarm triggers
// - trigger source: instrument events, averaged or instantaneous concentration
// - concentration sources trigger when the selected value exceeds the level
// - threshold level accepts 00.001 to 10.000 mg/m3
// - alarm stays active for 1 to 60 seconds, then enters the lockout
// - no reactivation until a 1 to 60 minute lockout has passed
// - humidity setpoint accepts 0 to 100 percent
// - heater switches on when sample humidity rises above the setpoint
// - heater switches off once humidity falls one percent below setpoint
// - humidity setpoint defaults to 50 percent
// - self-test interval: 15 minutes, 1, 2, 12 or 24 hours
// - each self-test run completes within three minutes
// - normal sampling is suspended while a self-test runs
// - zero phase runs the zero pump and captures a baseline
// - span phase energises the span solenoid to check the detector
// - span-enable setting lets the self-test skip the span phase
//
// The register addresses and the AXI4-Lite slave port were decided locally.
module ahs_ctrl #(
  parameter int unsigned SEC_CYCLES = ahs_pkg::SEC_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic inst_event,
  input wire logic [13:0] conc_avg,
  input wire logic [13:0] conc_rt,
  input wire logic [7:0] sample_humidity_reading,
  output logic alarm_contact_closed,
  output logic heater_on,
  output logic zero_pump_on,
  output logic span_solenoid_on,
  output logic sampling_enable,
  output logic baseline_capture,
  output logic irq
);
  import ahs_pkg::*;

  ahs_cfg_t cfg_q;
  logic [13:0] level_q;
  logic [5:0] hold_q;
  logic [5:0] lock_q;
  logic [6:0] hum_sp_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_mask_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick;
  ahs_al_t al_q;
  logic [11:0] al_cnt_q;
  logic trig;
  logic heater_q;
  ahs_st_t st_q;
  logic [7:0] st_cnt_q;
  logic [16:0] per_cnt_q;
  logic [16:0] per_target;
  logic base_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] wr_cur;
  logic [31:0] wr_new;
  logic [2:0] irq_ev;
  logic [2:0] irq_clr;
  logic hum_above;
  logic hum_below;

  // byte-lane merge of a write into the current register word
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // keep a written value inside its legal range
  function automatic logic [13:0] clamp(input logic [13:0] v, input logic [13:0] lo, input logic [13:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // register word seen by software at a given byte address
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    unique case (a)
      OFS_CTRL: return {26'h0, cfg_q};
      OFS_LEVEL: return {18'h0, level_q};
      OFS_TIMING: return {18'h0, lock_q, 2'b00, hold_q};
      OFS_HUM: return {25'h0, hum_sp_q};
      OFS_STATUS: return {26'h0, alarm_contact_closed, st_q, heater_q, al_q};
      OFS_IRQ_STAT: return {29'h0, irq_st_q};
      OFS_IRQ_MASK: return {29'h0, irq_mask_q};
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_IRQ_MASK);
  endfunction

  // write channel: address and data taken together, one write in flight
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb
  begin
    wr_cur = reg_word(s_axi_awaddr);
    wr_new = merge(wr_cur, s_axi_wdata, s_axi_wstrb);
  end

  // write response, held until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // read data captured at address acceptance, held until rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= reg_word(s_axi_araddr);
      rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // configuration registers; out-of-range writes are clamped rather than refused
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q <= CFG_RST;
      level_q <= LEVEL_RST;
      hold_q <= HOLD_RST;
      lock_q <= LOCK_RST;
      hum_sp_q <= HUM_RST;
      irq_mask_q <= 3'h0;
    end
    else if (wr_fire)
    begin
      unique case (s_axi_awaddr)
        OFS_CTRL: cfg_q <= wr_new[5:0];
        OFS_LEVEL: level_q <= clamp(wr_new[13:0], LEVEL_MIN, LEVEL_MAX);
        OFS_TIMING:
        begin
          hold_q <= 6'(clamp({8'h0, wr_new[5:0]}, {8'h0, TIME_MIN}, {8'h0, TIME_MAX}));
          lock_q <= 6'(clamp({8'h0, wr_new[TIM_LOCK_LSB +: 6]}, {8'h0, TIME_MIN}, {8'h0, TIME_MAX}));
        end
        OFS_HUM: hum_sp_q <= 7'(clamp({7'h0, wr_new[6:0]}, 14'h0, {7'h0, HUM_MAX}));
        OFS_IRQ_MASK: irq_mask_q <= wr_new[2:0];
        default:
        begin
        end
      endcase
    end
  end

  // one-second timebase shared by all timers
  assign tick = (tick_cnt_q == TICK_W'(SEC_CYCLES - 1));
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
    begin
      tick_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // trigger source select; unused source code never triggers
  always_comb
  begin
    unique case (cfg_q.src)
      SRC_EVENT: trig = inst_event;
      SRC_AVG: trig = conc_avg > level_q;
      SRC_REAL: trig = conc_rt > level_q;
      default: trig = 1'b0;
    endcase
  end

  // alarm sequence: hold time counted first, lockout counted from its end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      al_q <= AL_IDLE;
      al_cnt_q <= 12'h0;
    end
    else
    begin
      unique case (al_q)
        AL_IDLE:
        begin
          if (trig)
          begin
            al_q <= AL_ACTIVE;
            al_cnt_q <= {6'h0, hold_q};
          end
        end
        AL_ACTIVE:
        begin
          if (tick && al_cnt_q == 12'h1)
          begin
            al_q <= AL_LOCK;
            al_cnt_q <= 12'(lock_q) * SEC_PER_MIN;
          end
          else if (tick)
          begin
            al_cnt_q <= al_cnt_q - 1'b1;
          end
        end
        AL_LOCK:
        begin
          if (tick && al_cnt_q == 12'h1)
          begin
            al_q <= AL_IDLE;
          end
          else if (tick)
          begin
            al_cnt_q <= al_cnt_q - 1'b1;
          end
        end
        default: al_q <= AL_IDLE;
      endcase
    end
  end

  // contact is normally closed; opening it is the alarm
  assign alarm_contact_closed = (al_q != AL_ACTIVE);

  // heater hysteresis: on above setpoint, off at one percent below, else hold
  assign hum_above = {1'b0, sample_humidity_reading} > {2'b00, hum_sp_q};
  assign hum_below = ({1'b0, sample_humidity_reading} + 9'h1) <= {2'b00, hum_sp_q};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      heater_q <= 1'b0;
    end
    else if (hum_above)
    begin
      heater_q <= 1'b1;
    end
    else if (hum_below)
    begin
      heater_q <= 1'b0;
    end
  end
  assign heater_on = heater_q;

  // self-test interval; unused codes fall back to the longest period
  always_comb
  begin
    unique case (cfg_q.period)
      3'h0: per_target = PER_15M;
      3'h1: per_target = PER_1H;
      3'h2: per_target = PER_2H;
      3'h3: per_target = PER_12H;
      default: per_target = PER_24H;
    endcase
  end

  // self-test sequence; the interval counts from the end of the previous run
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_IDLE;
      st_cnt_q <= 8'h0;
      per_cnt_q <= 17'h0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          if (tick && (per_cnt_q + 17'h1) >= per_target)
          begin
            st_q <= ST_ZERO;
            st_cnt_q <= ZERO_SEC;
            per_cnt_q <= 17'h0;
          end
          else if (tick)
          begin
            per_cnt_q <= per_cnt_q + 17'h1;
          end
        end
        ST_ZERO:
        begin
          if (tick && st_cnt_q == 8'h1)
          begin
            st_q <= cfg_q.span_en ? ST_SPAN : ST_IDLE;
            st_cnt_q <= SPAN_SEC;
          end
          else if (tick)
          begin
            st_cnt_q <= st_cnt_q - 8'h1;
          end
        end
        ST_SPAN:
        begin
          if (tick && st_cnt_q == 8'h1)
          begin
            st_q <= ST_IDLE;
          end
          else if (tick)
          begin
            st_cnt_q <= st_cnt_q - 8'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // baseline strobe at the close of the zero phase, when the optics have flushed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      base_q <= 1'b0;
    end
    else
    begin
      base_q <= (st_q == ST_ZERO) && tick && (st_cnt_q == 8'h1);
    end
  end

  assign baseline_capture = base_q;
  assign zero_pump_on = (st_q == ST_ZERO);
  assign span_solenoid_on = (st_q == ST_SPAN);
  assign sampling_enable = (st_q == ST_IDLE);

  // events: alarm fired, self-test finished, heater switched on
  assign irq_ev[0] = (al_q == AL_IDLE) && trig;
  assign irq_ev[1] = (st_q != ST_IDLE) && tick && (st_cnt_q == 8'h1) && !(st_q == ST_ZERO && cfg_q.span_en);
  assign irq_ev[2] = !heater_q && hum_above;
  assign irq_clr = (wr_fire && s_axi_awaddr == OFS_IRQ_STAT && s_axi_wstrb[0]) ? s_axi_wdata[2:0] : 3'h0;

  // sticky status, write one to clear; a new event beats a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_st_q <= 3'h0;
    end
    else
    begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
    end
  end
  assign irq = |(irq_st_q & irq_mask_q);

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_contact;
    (al_q == AL_ACTIVE) |-> !alarm_contact_closed ##1 (al_q != AL_IDLE);
  endproperty
  a_contact: assert property (p_contact) else $error("contact not open while alarm active");

  property p_event_trig;
    (al_q == AL_IDLE && cfg_q.src == SRC_EVENT && inst_event) |=> !alarm_contact_closed;
  endproperty
  a_event_trig: assert property (p_event_trig) else $error("instrument event did not open contact");

  property p_conc_trig;
    (al_q == AL_IDLE && cfg_q.src == SRC_AVG && conc_avg > level_q) |=> (al_q == AL_ACTIVE);
  endproperty
  a_conc_trig: assert property (p_conc_trig) else $error("average above level did not trigger");

  property p_level_range;
    level_q >= LEVEL_MIN && level_q <= LEVEL_MAX;
  endproperty
  a_level_range: assert property (p_level_range) else $error("threshold level out of range");

  property p_hold_end;
    (al_q == AL_ACTIVE && tick && al_cnt_q == 12'h1) |=> (al_q == AL_LOCK) && alarm_contact_closed;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("active period did not end on time");

  property p_lock_load;
    (al_q == AL_ACTIVE) ##1 (al_q == AL_LOCK) |-> (al_cnt_q == 12'($past(lock_q)) * SEC_PER_MIN);
  endproperty
  a_lock_load: assert property (p_lock_load) else $error("lockout not loaded in minutes");

  property p_hum_range;
    hum_sp_q <= HUM_MAX;
  endproperty
  a_hum_range: assert property (p_hum_range) else $error("humidity setpoint out of range");

  property p_heat_on;
    hum_above |=> heater_on;
  endproperty
  a_heat_on: assert property (p_heat_on) else $error("heater not on above setpoint");

  property p_heat_off;
    hum_below |=> !heater_on;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("heater not off below band");

  property p_band;
    (!hum_above && !hum_below) |=> $stable(heater_on);
  endproperty
  a_band: assert property (p_band) else $error("heater changed inside band");

  property p_test_len;
    (st_q != ST_IDLE) |-> (st_cnt_q <= ZERO_SEC) && (st_cnt_q != 8'h0);
  endproperty
  a_test_len: assert property (p_test_len) else $error("self-test phase count out of bounds");

  property p_no_sample;
    (st_q != ST_IDLE) |-> !sampling_enable && (zero_pump_on != span_solenoid_on);
  endproperty
  a_no_sample: assert property (p_no_sample) else $error("sampling during self-test");

  property p_skip_span;
    (st_q == ST_ZERO && tick && st_cnt_q == 8'h1 && !cfg_q.span_en) |=> sampling_enable ##1 !span_solenoid_on;
  endproperty
  a_skip_span: assert property (p_skip_span) else $error("span ran while disabled");

  property p_ignore;
    (al_q == AL_LOCK && trig && !(tick && al_cnt_q == 12'h1)) |=> (al_q == AL_LOCK);
  endproperty
  a_ignore: assert property (p_ignore) else $error("trigger during lockout not ignored");

  c_alarm_cycle: cover property ((al_q == AL_ACTIVE) ##1 (al_q == AL_LOCK));
  c_span_run: cover property ((st_q == ST_ZERO) ##1 (st_q == ST_SPAN));
  c_heater_on: cover property ($rose(heater_on));
endmodule

/* core/ahs_pkg.sv */
// shared constants, types and register map for the alarm, heater and self-test controller
package ahs_pkg;
  // clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned SEC_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 25;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_TIMING = 8'h08;
  localparam logic [7:0] OFS_HUM = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // field positions
  localparam int unsigned TIM_LOCK_LSB = 8;
  // limits and reset values; level is in ug/m3, 1 = 00.001 mg/m3
  localparam logic [13:0] LEVEL_MIN = 14'h0001;
  localparam logic [13:0] LEVEL_MAX = 14'h2710;
  localparam logic [13:0] LEVEL_RST = 14'h0064;
  localparam logic [5:0] TIME_MIN = 6'h01;
  localparam logic [5:0] TIME_MAX = 6'h3c;
  localparam logic [5:0] HOLD_RST = 6'h0a;
  localparam logic [5:0] LOCK_RST = 6'h0a;
  localparam logic [6:0] HUM_MAX = 7'h64;
  localparam logic [6:0] HUM_RST = 7'h32;
  localparam logic [11:0] SEC_PER_MIN = 12'h03c;
  // self-test timing in seconds; both phases together stay inside the limit
  localparam logic [7:0] TEST_MAX_SEC = 8'hb4;
  localparam logic [7:0] ZERO_SEC = TEST_MAX_SEC / 8'h02;
  localparam logic [7:0] SPAN_SEC = TEST_MAX_SEC / 8'h02;
  localparam logic [16:0] PER_15M = 17'h00384;
  localparam logic [16:0] PER_1H = 17'h00e10;
  localparam logic [16:0] PER_2H = 17'h01c20;
  localparam logic [16:0] PER_12H = 17'h0a8c0;
  localparam logic [16:0] PER_24H = 17'h15180;
  localparam logic [2:0] PERIOD_RST = 3'h4;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {SRC_EVENT = 2'b00, SRC_AVG = 2'b01, SRC_REAL = 2'b10} ahs_src_t;
  typedef enum logic [1:0] {AL_IDLE = 2'b00, AL_ACTIVE = 2'b01, AL_LOCK = 2'b11} ahs_al_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ZERO = 2'b01, ST_SPAN = 2'b11} ahs_st_t;
  typedef struct packed {
    logic [2:0] period;
    logic span_en;
    ahs_src_t src;
  } ahs_cfg_t;
  localparam ahs_cfg_t CFG_RST = '{period: PERIOD_RST, span_en: 1'b1, src: SRC_EVENT};
endpackage

/* testbench/ahs_lamp_model.sv */
// behavioural warning lamp or logger input watching the alarm contact pair
module ahs_lamp_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic contact_closed,
  output int open_count,
  output int last_len
);
  timeunit 1ns;
  timeprecision 1ns;
  int run_len;
  // an unknown level counts as open: a real input cannot tell x from open
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      open_count <= 0;
      run_len <= 0;
      last_len <= 0;
    end
    else if (contact_closed !== 1'b1)
    begin
      if (run_len == 0)
        open_count <= open_count + 1;
      run_len <= run_len + 1;
    end
    else if (run_len != 0)
    begin
      last_len <= run_len;
      run_len <= 0;
    end
  end
endmodule

/* testbench/ahs_ctrl_tb.sv */
// self-checking bench for the alarm, heater and self-test controller
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module ahs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ahs_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, inst_event;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic heater_on, zero_pump_on, span_solenoid_on, sampling_enable, baseline_capture, contact;
  logic [7:0] awaddr, araddr, hum;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [13:0] conc_avg, conc_rt;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int err_total, n_checks, open_count, last_len, bl_cnt, seed, g;
  logic [7:0] tbl[8] = '{8'h33, 8'h32, 8'h31, 8'h32, 8'h33, 8'h30, 8'h00, 8'hff};
  logic exp_h;
  int v;

  ahs_ctrl #(.SEC_CYCLES(4)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .inst_event(inst_event), .conc_avg(conc_avg), .conc_rt(conc_rt),
    .sample_humidity_reading(hum), .alarm_contact_closed(contact), .heater_on(heater_on),
    .zero_pump_on(zero_pump_on), .span_solenoid_on(span_solenoid_on),
    .sampling_enable(sampling_enable), .baseline_capture(baseline_capture), .irq(irq)
  );

  ahs_lamp_model lamp (
    .aclk(aclk), .aresetn(aresetn), .contact_closed(contact),
    .open_count(open_count), .last_len(last_len)
  );

  // 20 mhz clock
  always #25 aclk = ~aclk;

  // response monitor: oldest note is compared whenever a response is taken
  always @(posedge aclk)
  begin : mon
    logic [1:0] eb;
    logic [33:0] er;
    if (bvalid && bready)
    begin
      eb = exp_b.pop_front();
      `CHK(bresp, eb)
    end
    if (rvalid && rready)
    begin
      er = exp_r.pop_front();
      `CHK({rresp, rdata}, er)
    end
  end

  // baseline pulses, one per zero phase
  always @(posedge aclk)
    if (aresetn && baseline_capture === 1'b1)
      bl_cnt++;

  task automatic close_out();
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // address and data offered together, each held until taken
  // bready stays high between writes, so a back-to-back call never drives it twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (!(awready && wready)) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    while (!bvalid) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    exp_r.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
  endtask

  // one self-test run; returns idle cycles before the zero phase began
  task automatic st_run(input logic span, output int gap);
    int z;
    int s;
    gap = 0;
    z = 0;
    s = 0;
    while (!zero_pump_on)
    begin
      @(posedge aclk);
      gap++;
    end
    while (zero_pump_on)
    begin
      `CHK(sampling_enable | span_solenoid_on, 1'b0)
      @(posedge aclk);
      z++;
    end
    while (span_solenoid_on)
    begin
      `CHK(sampling_enable | zero_pump_on, 1'b0)
      @(posedge aclk);
      s++;
    end
    `CHK(z >= 352 && z <= 364, 1'b1)
    `CHK(span ? (s >= 352 && s <= 364) : (s == 0), 1'b1)
    `CHK(z + s <= 720, 1'b1)
    @(posedge aclk);
    `CHK(sampling_enable, 1'b1)
  endtask

  // hang guard: the whole sequence needs about 8300 cycles
  initial
  begin
    repeat (25000) @(posedge aclk);
    err_total++;
    close_out();
  end

  initial
  begin
    seed = 32'h282d58ab;
    {aclk, awvalid, wvalid, bready, arvalid, rready, inst_event} = '0;
    {awaddr, araddr, wdata, conc_avg, conc_rt, hum} = '0;
    wstrb = 4'hf;
    exp_h = 1'b0;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values
    rd(OFS_CTRL, RESP_OKAY, 32'h24);
    rd(OFS_LEVEL, RESP_OKAY, 32'h64);
    rd(OFS_TIMING, RESP_OKAY, 32'h0a0a);
    rd(OFS_HUM, RESP_OKAY, 32'h32);
    rd(OFS_STATUS, RESP_OKAY, 32'h20);
    rd(OFS_IRQ_MASK, RESP_OKAY, 32'h0);
    // range limits and an unmapped place
    wr(OFS_LEVEL, 32'h0, RESP_OKAY);
    rd(OFS_LEVEL, RESP_OKAY, 32'h1);
    wr(OFS_LEVEL, 32'hffff, RESP_OKAY);
    rd(OFS_LEVEL, RESP_OKAY, 32'h2710);
    wr(OFS_LEVEL, 32'h64, RESP_OKAY);
    // only byte lane 0 enabled: the upper byte keeps its current value
    wstrb <= 4'h1;
    wr(OFS_LEVEL, 32'h3f80, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFS_LEVEL, RESP_OKAY, 32'h80);
    wr(OFS_LEVEL, 32'h64, RESP_OKAY);
    wr(8'h1c, 32'h1, RESP_SLVERR);
    rd(8'h1c, RESP_SLVERR, 32'h0);
    wr(OFS_STATUS, 32'hff, RESP_OKAY);
    rd(OFS_STATUS, RESP_OKAY, 32'h20);
    // heater: boundary table then random readings around the 50 percent setpoint
    for (int i = 0; i < 28; i++)
    begin
      v = (i < 8) ? tbl[i] : ($unsigned($random(seed)) % 120);
      hum <= v[7:0];
      @(posedge aclk);
      if (v > 50)
        exp_h = 1'b1;
      else if (v + 1 <= 50)
        exp_h = 1'b0;
      @(posedge aclk);
      `CHK(heater_on, exp_h)
    end
    wr(OFS_HUM, 32'hff, RESP_OKAY);
    rd(OFS_HUM, RESP_OKAY, 32'h64);
    // alarm on averaged level, hold 2 s, lockout 1 min
    wr(OFS_IRQ_STAT, 32'h7, RESP_OKAY);
    wr(OFS_TIMING, 32'h0102, RESP_OKAY);
    conc_avg <= 14'h64;
    conc_rt <= 14'h1388;
    // event raised only once the average source is in force, else it fires the event source
    wr(OFS_CTRL, 32'h25, RESP_OKAY);
    inst_event <= 1'b1;
    repeat (20) @(posedge aclk);
    `CHK(open_count, 0)
    conc_avg <= 14'h65;
    repeat (20) @(posedge aclk);
    `CHK(open_count, 1)
    `CHK(last_len >= 4 && last_len <= 8, 1'b1)
    rd(OFS_IRQ_STAT, RESP_OKAY, 32'h1);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
    `CHK(irq, 1'b0)
    repeat (150) @(posedge aclk);
    `CHK(open_count, 1)
    repeat (120) @(posedge aclk);
    `CHK(open_count, 2)
    conc_avg <= 14'h0;
    repeat (300) @(posedge aclk);
    // event source, then instantaneous source
    wr(OFS_CTRL, 32'h24, RESP_OKAY);
    repeat (20) @(posedge aclk);
    `CHK(open_count, 3)
    inst_event <= 1'b0;
    repeat (300) @(posedge aclk);
    wr(OFS_CTRL, 32'h26, RESP_OKAY);
    repeat (20) @(posedge aclk);
    `CHK(open_count, 4)
    conc_rt <= 14'h0;
    // self-test every 15 minutes, span on, then span off
    wr(OFS_CTRL, 32'h04, RESP_OKAY);
    st_run(1'b1, g);
    wr(OFS_CTRL, 32'h00, RESP_OKAY);
    st_run(1'b0, g);
    `CHK(g >= 3584 && g <= 3604, 1'b1)
    `CHK(bl_cnt, 2)
    // alarm fired again after the clear, and both self-tests finished; heater not switched on since the clear
    rd(OFS_IRQ_STAT, RESP_OKAY, 32'h3);
    close_out();
  end
endmodule
